// ---- design/eis_pkg.sv ----
package eis_pkg;
	// register map, word aligned byte addresses
	localparam logic [3:0] ADDR_SENSE_A = 4'h0;
	localparam logic [3:0] ADDR_SENSE_B = 4'h4;
	localparam logic [3:0] ADDR_PEND = 4'h8;
	localparam logic [3:0] ADDR_WAKE = 4'hc;
	// field positions
	localparam int SRC_ZERO_LSB = 0;
	localparam int SRC_ONE_LSB = 2;
	localparam int SRC_TWO_LSB = 4;
	localparam int SRC_THREE_LSB = 0;
	localparam int SRC_FOUR_LSB = 2;
	localparam logic [7:0] SENSE_A_MASK = 8'h3f;
	localparam logic [7:0] SENSE_B_MASK = 8'h0f;
	localparam logic [7:0] SENSE_RESET = 8'h00;
	localparam int NUM_SRC = 5;
	localparam int SRC_TWO = 2;
	localparam int SRC_FOUR = 4;

	// two-bit sensitivity encodings
	typedef enum logic [1:0] {
		SENSE_FALL_LOW = 2'h0,
		SENSE_RISE = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_BOTH = 2'h3
	} eis_sense_t;

	// per-source request bundle toward the core
	typedef struct packed {
		logic [NUM_SRC-1:0] req;
		logic [NUM_SRC-1:0] wake;
	} eis_req_t;
endpackage

// ---- design/eis_edge_det.sv ----
// one source: synchronise, NAND-combine pins, classify edges by mode
module eis_edge_det
	import eis_pkg::*;
#(
	parameter int PINS = 8
) (
	input wire logic clk, // core clock
	input wire logic nrst, // synchronous reset, active low
	input wire logic clkEn, // freezes state while low
	input wire logic [PINS-1:0] pinIn, // raw port pins
	input wire logic [PINS-1:0] pinIrqEn, // pins configured as interrupt inputs
	input wire eis_sense_t sense, // selected sensitivity
	output logic event_o, // edge event of selected kind, one cycle
	output logic lowLevel, // combined input is low
	output logic fallEdge // combined input fell this cycle
);
	logic [PINS-1:0] sync1_r;
	logic [PINS-1:0] sync2_r;
	logic comb_r;
	logic comb;

	// two flops before pins are looked at; they reset to the idle high level
	// of the pins so that leaving reset makes no false edge or low level
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_r <= '1;
			sync2_r <= '1;
		end else if (clkEn) begin
			sync1_r <= pinIn;
			sync2_r <= sync1_r;
		end
	end

	// NAND of enabled pins: any enabled low pin holds the source low
	assign comb = ~|(pinIrqEn & ~sync2_r);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			comb_r <= 1'b1;
		end else if (clkEn) begin
			comb_r <= comb;
		end
	end

	assign fallEdge = comb_r & ~comb;
	assign lowLevel = ~comb;

	// mode decode; a low source never rises, so rising mode stays masked
	always_comb begin
		unique case (sense)
			SENSE_FALL_LOW: event_o = fallEdge;
			SENSE_RISE: event_o = ~comb_r & comb;
			SENSE_FALL: event_o = fallEdge;
			SENSE_BOTH: event_o = comb_r ^ comb;
		endcase
	end
endmodule

// ---- design/ext_irq_sense.sv ----
// Notes on behaviour
// - The first sense register holds source two in bits 5:4, source one in 3:2, zero in 1:0.
// - Source two is fed from port C pins using bits 5:4 of the first register.
// - Source one is fed from port B pins using bits 3:2 of the first register.
// - Source zero is fed from port A pins using bits 1:0 of the first register.
// - Codes 00 falling plus low level, 01 rising, 10 falling, 11 both edges.
// - The second register holds source four in bits 3:2 and three in 1:0, 7:4 reserved.
// - Sense registers take writes only while the core interrupt mask bit is set.
// - A new sensitivity value for a source clears that source's pending request.
// - A falling edge on source two never wakes the device from halt modes.
// - Both sense registers reset to zero.
// - Edge requests are latched and cleared when the core enters the source's routine.
// - A request is vectored only when pending and the core mask bit is clear.
// - A low level on any enabled pin of a NAND source masks it even in rising mode.
//
// Our own choices: the address map and register access over Wishbone.
module ext_irq_sense
	import eis_pkg::*;
(
	input wire logic clk, // core clock, 10 MHz
	input wire logic nrst, // synchronous reset, active low
	input wire logic clkEn, // clock enable, freezes all state when low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write enable
	input wire logic [3:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic ccMaskBit, // core global interrupt mask bit
	input wire logic haltMode, // core in halt, active-halt or auto-wakeup-halt
	input wire logic [7:0] portAIn, // port A pins, feed source zero
	input wire logic [7:0] portBIn, // port B pins, feed source one
	input wire logic [7:0] portCIn, // port C pins, feed source two
	input wire logic [7:0] portDIn, // pins feeding source three
	input wire logic [7:0] portEIn, // pins feeding source four
	input wire logic [39:0] pinIrqEn, // per-pin interrupt enables, 8 per source
	input wire logic [NUM_SRC-1:0] svcEnter, // core enters a source's routine, pulse
	output logic [NUM_SRC-1:0] irqVector, // request allowed to vector now
	output eis_req_t reqBus // pending requests and wake requests
);
	logic [7:0] senseA_r; // ext_irq_sense_ctrl_a
	logic [7:0] senseB_r; // ext_irq_sense_ctrl_b
	logic [NUM_SRC-1:0] pend_r;
	logic [NUM_SRC-1:0] wake_r;
	logic ack_r;
	logic [31:0] rdat_r;
	logic busReq;
	logic wrA;
	logic wrB;
	logic [NUM_SRC-1:0] senseChg;
	logic [NUM_SRC-1:0] evt;
	logic [NUM_SRC-1:0] low;
	logic [NUM_SRC-1:0] fall;
	logic [NUM_SRC-1:0] levelMode;
	logic [NUM_SRC-1:0] wakeEvt;
	eis_sense_t srcSense [NUM_SRC];
	logic [7:0] srcPins [NUM_SRC];
	logic [7:0] newA;
	logic [7:0] newB;

	assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
	// reserved bits are dropped on write so they always read zero
	assign newA = wb_dat_i[7:0] & SENSE_A_MASK;
	assign newB = wb_dat_i[7:0] & SENSE_B_MASK;
	// writes are ignored unless the core mask bit is set
	assign wrA = busReq & wb_we_i & wb_sel_i[0] & ccMaskBit
		& (wb_adr_i == ADDR_SENSE_A);
	assign wrB = busReq & wb_we_i & wb_sel_i[0] & ccMaskBit
		& (wb_adr_i == ADDR_SENSE_B);

	// field extraction per source
	assign srcSense[0] = eis_sense_t'(senseA_r[SRC_ZERO_LSB +: 2]);
	assign srcSense[1] = eis_sense_t'(senseA_r[SRC_ONE_LSB +: 2]);
	assign srcSense[2] = eis_sense_t'(senseA_r[SRC_TWO_LSB +: 2]);
	assign srcSense[3] = eis_sense_t'(senseB_r[SRC_THREE_LSB +: 2]);
	assign srcSense[4] = eis_sense_t'(senseB_r[SRC_FOUR_LSB +: 2]);
	assign srcPins[0] = portAIn;
	assign srcPins[1] = portBIn;
	assign srcPins[2] = portCIn;
	assign srcPins[3] = portDIn;
	assign srcPins[4] = portEIn;

	// a field that changes value on an accepted write discards the pending request
	assign senseChg[0] = wrA & (newA[SRC_ZERO_LSB +: 2] != senseA_r[SRC_ZERO_LSB +: 2]);
	assign senseChg[1] = wrA & (newA[SRC_ONE_LSB +: 2] != senseA_r[SRC_ONE_LSB +: 2]);
	assign senseChg[2] = wrA & (newA[SRC_TWO_LSB +: 2] != senseA_r[SRC_TWO_LSB +: 2]);
	assign senseChg[3] = wrB & (newB[SRC_THREE_LSB +: 2] != senseB_r[SRC_THREE_LSB +: 2]);
	assign senseChg[4] = wrB & (newB[SRC_FOUR_LSB +: 2] != senseB_r[SRC_FOUR_LSB +: 2]);

	// one edge detector per source
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : gSrc
			eis_edge_det #(.PINS(8)) uDet (
				.clk(clk),
				.nrst(nrst),
				.clkEn(clkEn),
				.pinIn(srcPins[g]),
				.pinIrqEn(pinIrqEn[g*8 +: 8]),
				.sense(srcSense[g]),
				.event_o(evt[g]),
				.lowLevel(low[g]),
				.fallEdge(fall[g])
			);
			assign levelMode[g] = (srcSense[g] == SENSE_FALL_LOW);
			// source two may not wake on a falling edge in any halt mode
			if (g == SRC_TWO) begin : gNoFallWake
				assign wakeEvt[g] = evt[g] & ~fall[g];
			end else begin : gWake
				assign wakeEvt[g] = evt[g] | (levelMode[g] & low[g]);
			end
		end
	endgenerate

	// sensitivity registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			senseA_r <= SENSE_RESET;
			senseB_r <= SENSE_RESET;
		end else if (clkEn) begin
			if (wrA) begin
				senseA_r <= newA;
			end
			if (wrB) begin
				senseB_r <= newB;
			end
		end
	end

	// pending latch: event wins over service clear; a sense change discards
	// the old request but a fresh event in the same cycle still latches
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pend_r <= '0;
		end else if (clkEn) begin
			pend_r <= (pend_r & ~svcEnter & ~senseChg) | evt;
		end
	end

	// wake requests only while halted; cleared on leaving halt
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wake_r <= '0;
		end else if (clkEn) begin
			if (haltMode) begin
				wake_r <= wake_r | wakeEvt;
			end else begin
				wake_r <= '0;
			end
		end
	end

	// level mode keeps asking while the combined input stays low
	assign reqBus.req = pend_r | (levelMode & low);
	assign reqBus.wake = wake_r;
	// vector only when mask bit is clear, otherwise stays pending
	assign irqVector = ccMaskBit ? '0 : reqBus.req;

	// bus answer one cycle after request, ack drops the cycle after
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			rdat_r <= '0;
		end else if (clkEn) begin
			ack_r <= busReq;
			if (busReq & ~wb_we_i) begin
				unique case (wb_adr_i)
					ADDR_SENSE_A: rdat_r <= {24'h000000, senseA_r};
					ADDR_SENSE_B: rdat_r <= {24'h000000, senseB_r};
					ADDR_PEND: rdat_r <= {27'h0, reqBus.req};
					ADDR_WAKE: rdat_r <= {27'h0, wake_r};
					default: rdat_r <= '0; // unmapped reads as zero
				endcase
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// writes with mask clear leave both registers as they were
	AST_WR_BLOCKED: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && busReq && wb_we_i && !ccMaskBit) |=> $stable(senseA_r) && $stable(senseB_r))
		else $error("sense register changed while mask bit clear");

	// accepted write to register a or b lands with reserved bits cleared
	AST_WR_A: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && wrA) |=> senseA_r == ($past(wb_dat_i[7:0]) & SENSE_A_MASK))
		else $error("sense register a write not stored");
	AST_WR_B: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && wrB) |=> senseB_r[7:4] == 4'h0 && senseB_r[3:0] == $past(wb_dat_i[3:0]))
		else $error("sense register b write not stored");
	AST_RESET_ZERO: assert property (@(posedge clk)
		!nrst |=> senseA_r == 8'h00 && senseB_r == 8'h00)
		else $error("sense registers not zero after reset");

	// reserved bits never hold a one, whatever software writes
	AST_RSV_A: assert property (@(posedge clk) disable iff (!nrst)
		senseA_r[7:6] == 2'h0)
		else $error("reserved bits of register a set");
	AST_RSV_B: assert property (@(posedge clk) disable iff (!nrst)
		senseB_r[7:4] == 4'h0)
		else $error("reserved bits of register b set");

	// without an accepted write the registers keep their value
	AST_KEEP_A: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && !wrA) |=> $stable(senseA_r))
		else $error("sense register a changed without write");
	AST_KEEP_B: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && !wrB) |=> $stable(senseB_r))
		else $error("sense register b changed without write");

	// a sense change without a new event leaves nothing pending
	AST_CHG_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && senseChg[0] && !evt[0]) |=> !pend_r[0])
		else $error("sense change did not discard request");
	AST_CHG_CLEARS_1: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && senseChg[1] && !evt[1]) |=> !pend_r[1])
		else $error("sense change did not discard request one");
	AST_CHG_CLEARS_2: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && senseChg[2] && !evt[2]) |=> !pend_r[2])
		else $error("sense change did not discard request two");
	AST_CHG_CLEARS_3: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && senseChg[3] && !evt[3]) |=> !pend_r[3])
		else $error("sense change did not discard request three");
	AST_CHG_CLEARS_4: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && senseChg[4] && !evt[4]) |=> !pend_r[4])
		else $error("sense change did not discard request four");

	// service entry without a new event clears the latch
	AST_SVC_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && svcEnter[1] && !evt[1]) |=> !pend_r[1])
		else $error("service entry did not clear request");
	AST_SVC_CLEARS_0: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && svcEnter[0] && !evt[0]) |=> !pend_r[0])
		else $error("service entry did not clear request zero");
	AST_SVC_CLEARS_2: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && svcEnter[2] && !evt[2]) |=> !pend_r[2])
		else $error("service entry did not clear request two");
	AST_SVC_CLEARS_3: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && svcEnter[3] && !evt[3]) |=> !pend_r[3])
		else $error("service entry did not clear request three");
	AST_SVC_CLEARS_4: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && svcEnter[4] && !evt[4]) |=> !pend_r[4])
		else $error("service entry did not clear request four");

	// every edge event is latched, even against a clear in the same cycle
	AST_EDGE_LATCH: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && evt[3]) |=> pend_r[3])
		else $error("edge event not latched");
	AST_EDGE_LATCH_0: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && evt[0]) |=> pend_r[0])
		else $error("edge event zero not latched");
	AST_EDGE_LATCH_1: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && evt[1]) |=> pend_r[1])
		else $error("edge event one not latched");
	AST_EDGE_LATCH_2: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && evt[2]) |=> pend_r[2])
		else $error("edge event two not latched");
	AST_EDGE_LATCH_4: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && evt[4]) |=> pend_r[4])
		else $error("edge event four not latched");

	// a latched request stays until serviced or discarded, masked or not
	AST_PEND_STAYS_0: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && pend_r[0] && !svcEnter[0] && !senseChg[0]) |=> pend_r[0])
		else $error("request zero lost while pending");
	AST_PEND_STAYS_1: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && pend_r[1] && !svcEnter[1] && !senseChg[1]) |=> pend_r[1])
		else $error("request one lost while pending");
	AST_PEND_STAYS_2: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && pend_r[2] && !svcEnter[2] && !senseChg[2]) |=> pend_r[2])
		else $error("request two lost while pending");
	AST_PEND_STAYS_3: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && pend_r[3] && !svcEnter[3] && !senseChg[3]) |=> pend_r[3])
		else $error("request three lost while pending");
	AST_PEND_STAYS_4: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && pend_r[4] && !svcEnter[4] && !senseChg[4]) |=> pend_r[4])
		else $error("request four lost while pending");

	// vectoring follows the mask bit
	AST_NO_VEC_MASKED: assert property (@(posedge clk) disable iff (!nrst)
		ccMaskBit |-> irqVector == '0)
		else $error("vector while mask bit set");
	AST_VEC_OPEN: assert property (@(posedge clk) disable iff (!nrst)
		!ccMaskBit |-> irqVector == reqBus.req)
		else $error("request not offered with mask bit clear");
	AST_LEVEL_HOLD: assert property (@(posedge clk) disable iff (!nrst)
		(levelMode[0] && low[0]) |-> reqBus.req[0])
		else $error("low level request dropped");

	// a rising-edge source held low by one enabled pin stays quiet
	AST_RISE_MASKED: assert property (@(posedge clk) disable iff (!nrst)
		(srcSense[1] == SENSE_RISE && low[1]) |-> !evt[1])
		else $error("rising event while source held low");
	// falling-only mode reports falls and nothing else; rising-only never a fall
	AST_FALL_ONLY: assert property (@(posedge clk) disable iff (!nrst)
		(srcSense[2] == SENSE_FALL) |-> evt[2] == fall[2])
		else $error("falling-only mode event mismatch");
	AST_RISE_ONLY: assert property (@(posedge clk) disable iff (!nrst)
		(srcSense[4] == SENSE_RISE) |-> !(evt[4] && fall[4]))
		else $error("rising-only mode took a falling edge");

	// wake requests come only in halt, never from a source two fall
	AST_TWO_NO_FALL_WAKE: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && haltMode && !wake_r[2] && fall[2]) |=> !wake_r[2])
		else $error("source two woke on falling edge");
	AST_WAKE_OUT_HALT: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && !haltMode) |=> wake_r == '0)
		else $error("wake request outside halt");
	AST_WAKE_EDGE: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && haltMode && evt[0]) |=> wake_r[0])
		else $error("edge event in halt gave no wake");

	// bus: one ack per taken request, none otherwise
	AST_ACK_ONE: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && wb_ack_o) |=> !wb_ack_o)
		else $error("ack held more than one cycle");
	AST_ACK_AFTER_REQ: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && busReq) |=> wb_ack_o)
		else $error("taken request not acknowledged");
	AST_ACK_NEEDS_REQ: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && !busReq) |=> !wb_ack_o)
		else $error("ack without request");

	// a low clock enable freezes registers, latches and the bus answer
	AST_FREEZE_SENSE: assert property (@(posedge clk) disable iff (!nrst)
		!clkEn |=> $stable(senseA_r) && $stable(senseB_r))
		else $error("sense register moved while frozen");
	AST_FREEZE_PEND: assert property (@(posedge clk) disable iff (!nrst)
		!clkEn |=> $stable(pend_r) && $stable(wake_r))
		else $error("request latch moved while frozen");
	AST_FREEZE_ACK: assert property (@(posedge clk) disable iff (!nrst)
		!clkEn |=> $stable(wb_ack_o) && $stable(wb_dat_o))
		else $error("bus answer moved while frozen");

	// read data carries the register in the low byte, upper bits zero
	AST_READ_A: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && busReq && !wb_we_i && wb_adr_i == ADDR_SENSE_A)
		|=> wb_dat_o == {24'h000000, $past(senseA_r)})
		else $error("register a read data wrong");
	AST_READ_B: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && busReq && !wb_we_i && wb_adr_i == ADDR_SENSE_B)
		|=> wb_dat_o == {24'h000000, $past(senseB_r)})
		else $error("register b read data wrong");
	AST_READ_UPPER: assert property (@(posedge clk) disable iff (!nrst)
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read data bits set");
endmodule

// ---- bench/eis_core_model.sv ----
// core side: vectors the lowest pending source while allowed to
module eis_core_model
	import eis_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic nrst, // synchronous reset, active low
	input wire logic svcOn, // core may take interrupts
	input wire logic [NUM_SRC-1:0] irqVector, // requests allowed to vector
	output logic [NUM_SRC-1:0] svcEnter // routine entry pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] gap;

	// gap lets the cleared request settle before the next entry
	always_ff @(posedge clk) begin
		svcEnter <= '0;
		if (!nrst) begin
			gap <= 2'h0;
		end else if (gap != 2'h0) begin
			gap <= gap - 2'h1;
		end else if (svcOn && irqVector != '0) begin
			svcEnter <= irqVector & (~irqVector + 5'h1); // lowest index wins
			gap <= 2'h3;
		end
	end
endmodule

// ---- bench/tb_top.sv ----
module tb_top import eis_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, nrst = 0, clkEn = 1, cyc = 0, stb = 0, we = 0;
	logic ccMask = 1, halt = 0, svcOn = 0, clrWake = 0, ack;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic [7:0] pins [NUM_SRC] = '{default: 8'hff};
	logic [39:0] pinEn = {40{1'b1}};
	logic [NUM_SRC-1:0] irqVec, svc, wakeSeen = '0;
	eis_req_t reqBus;
	int errorCnt = 0, nTests = 0;

	initial forever #50 clk = ~clk;

	ext_irq_sense dut_u (.clk(clk), .nrst(nrst), .clkEn(clkEn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ccMaskBit(ccMask), .haltMode(halt), .portAIn(pins[0]),
		.portBIn(pins[1]), .portCIn(pins[2]), .portDIn(pins[3]), .portEIn(pins[4]),
		.pinIrqEn(pinEn), .svcEnter(svc), .irqVector(irqVec), .reqBus(reqBus));
	eis_core_model core_u (.clk(clk), .nrst(nrst), .svcOn(svcOn), .irqVector(irqVec),
		.svcEnter(svc));

	// wake pulses may be one cycle long, so keep them sticky
	always @(posedge clk) wakeSeen <= clrWake ? '0 : (wakeSeen | reqBus.wake);

	function automatic logic expFall(int m);
		return m != 1;
	endfunction
	function automatic logic expRise(int m);
		return m == 1 || m == 3;
	endfunction

	task automatic finishTest;
		if (errorCnt == 0 && nTests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
		nTests++;
		if (got !== exp) begin
			errorCnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// classic cycle: hold everything until ack is sampled high, release at that edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	// pin change needs three edges through the synchroniser before req shows;
	// wake requests stick for the whole halt, so a one-cycle dip clears them
	task automatic setPin(input int s, input int p, input logic v);
		logic hv;
		hv = halt;
		@(posedge clk);
		pins[s][p] <= v;
		clrWake <= 1;
		halt <= 0;
		@(posedge clk);
		clrWake <= 0;
		halt <= hv;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic serviceAll;
		@(posedge clk);
		ccMask <= 0;
		svcOn <= 1;
		repeat (8) @(posedge clk);
		ccMask <= 1;
		svcOn <= 0;
		@(negedge clk);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errorCnt++;
		finishTest();
	end

	initial begin
		logic [31:0] q;
		logic [7:0] v;
		int p;
		void'($urandom(99));
		repeat (12) @(posedge clk);
		nrst <= 1;
		wb(0, ADDR_SENSE_A, 8'h0, q);
		cmp(q, 32'h0, "sense a reset");
		wb(0, ADDR_SENSE_B, 8'h0, q);
		cmp(q, 32'h0, "sense b reset");
		wb(0, 4'h1, 8'h0, q);
		cmp(q, 32'h0, "unmapped read");
		@(posedge clk) ccMask <= 0;
		wb(1, ADDR_SENSE_A, 8'h15, q);
		wb(0, ADDR_SENSE_A, 8'h0, q);
		cmp(q, 32'h0, "write while unmasked");
		ccMask <= 1;
		repeat (4) begin
			v = 8'($urandom);
			wb(1, ADDR_SENSE_A, v & 8'h3f, q);
			wb(1, ADDR_SENSE_B, v, q);
			wb(0, ADDR_SENSE_A, 8'h0, q);
			cmp(q, {24'h0, v & 8'h3f}, "sense a");
			wb(0, ADDR_SENSE_B, 8'h0, q);
			cmp(q, {24'h0, v & 8'h0f}, "sense b");
		end
		wb(1, ADDR_SENSE_A, 8'h0, q);
		wb(1, ADDR_SENSE_B, 8'h0, q);
		halt <= 1;
		// every source in every mode, one random pin each
		for (int s = 0; s < NUM_SRC; s++) begin
			for (int m = 0; m < 4; m++) begin
				p = $urandom_range(7, 0);
				wb(1, (s < 3) ? ADDR_SENSE_A : ADDR_SENSE_B, 8'(m << (2 * (s % 3))), q);
				setPin(s, p, 0);
				cmp(reqBus.req[s], expFall(m), "fall req");
				cmp(irqVec[s], 0, "vector while masked");
				if (s != 2 || m > 1) cmp(wakeSeen[s], expFall(m) && s != 2, "fall wake");
				wb(0, ADDR_WAKE, 8'h0, q);
				cmp(q, (expFall(m) && s != 2) ? 32'h1 << s : 32'h0, "wake read");
				serviceAll();
				cmp(reqBus.req[s], m == 0, "after service");
				setPin(s, p, 1);
				if (m != 0) cmp(reqBus.req[s], expRise(m), "rise req");
				if (m != 0) cmp(wakeSeen[s], expRise(m), "rise wake");
				serviceAll();
			end
		end
		@(posedge clk) halt <= 0;
		// a held low pin blocks the rising edge of another
		wb(1, ADDR_SENSE_A, 8'h04, q);
		setPin(1, 3, 0);
		setPin(1, 0, 0);
		setPin(1, 0, 1);
		cmp(reqBus.req[1], 0, "nand masked");
		setPin(1, 3, 1);
		cmp(reqBus.req[1], 1, "nand released");
		serviceAll();
		// refused write keeps the request, a real change drops it
		wb(1, ADDR_SENSE_A, 8'h02, q);
		setPin(0, 0, 0);
		@(posedge clk) ccMask <= 0;
		wb(1, ADDR_SENSE_A, 8'h03, q);
		@(negedge clk);
		cmp(reqBus.req[0], 1, "refused change");
		wb(0, ADDR_PEND, 8'h0, q);
		cmp(q, 32'h1, "pending read");
		@(posedge clk) ccMask <= 1;
		wb(1, ADDR_SENSE_A, 8'h03, q);
		@(negedge clk);
		cmp(reqBus.req[0], 0, "change clears");
		setPin(0, 0, 1);
		serviceAll();
		// a low clock enable holds back a pin edge until it returns
		@(posedge clk) clkEn <= 0;
		setPin(0, 5, 0);
		cmp(reqBus.req[0], 0, "frozen");
		@(posedge clk) clkEn <= 1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		cmp(reqBus.req[0], 1, "thawed");
		setPin(0, 5, 1);
		serviceAll();
		wb(1, ADDR_SENSE_B, 8'h04, q);
		finishTest();
	end
endmodule
